// ---- src/name_id_config.sv ----
// Configurable network identity: NAME, extended identifier and address arbitration.
// Assumes a synchronous plain register port and a rival NAME supplied by the CAN controller.
//
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/1ps
`include "name_id_defs.svh"

// Function
// - Five-bit function instance, zero first, writable.
// - Three-bit ECU instance, zero first, writable.
// - Three-bit industry group, default zero.
// - Four-bit vehicle system instance, 0..15.
// - Seven-bit vehicle system field in NAME.
// - Eight-bit function, below 128 independent, FF.
// - Eleven-bit maker code fixed at factory.
// - Identity number set at manufacture.
// - Sixty-four-bit NAME of ten sub-fields.
// - Lower NAME keeps a contested address.
// - Priority in identifier, zero highest, default six.
// - Data page bit, default one.
// - PDU format 240+ broadcast, default 255.
// - PDU specific per format, default zero.
// - Low identifier byte is unique source address.
// - Parameter group number derived from fields.
// - Instance fields default to zero.
// - Assembled identifier readable by software.
// - Restore command reloads full factory defaults.
module name_id_config #(
    parameter logic [10:0] MAKER_CODE = 11'h155, // Arbitrary value, set per product.
    parameter logic [20:0] IDENT_NUM = `DEF_IDENT
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst_n,
    // Register port.
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Address claim arbitration.
    input wire logic claim_seen,
    input wire logic [63:0] rival_name,
    input wire logic [7:0] rival_addr,
    // Assembled identity.
    output name_id_pkg::name_t name_out,
    output name_id_pkg::can_id_t can_id,
    output logic [17:0] pgn,
    output logic broadcast,
    output logic func_indep,
    output logic addr_valid,
    output logic addr_lost
);

    // *************************************************************
    // Configuration storage.
    // *************************************************************
    logic [4:0] func_inst; // Function instance.
    logic [2:0] ecu_inst; // ECU instance.
    logic [2:0] ind_group; // Industry group.
    logic [3:0] vsys_inst; // Vehicle system instance.
    logic [6:0] vsys; // Vehicle system.
    logic [7:0] func; // Function code.
    logic [20:0] ident; // Identity number.
    logic [2:0] prio; // Message priority.
    logic dpage; // Data page.
    logic [7:0] pdu_fmt; // PDU format.
    logic [7:0] pdu_spec; // PDU specific.
    logic [7:0] src_addr; // Source address.
    logic ident_loaded; // Identity number captured after reset.
    name_id_pkg::restore_state_t state; // Restore sequencer.
    name_id_pkg::restore_state_t next_state;

    // *************************************************************
    // Decode.
    // *************************************************************
    // Writes to the read-only offsets match no strobe below, so they fall through
    // and leave every field as it was.
    wire wr_inst = reg_wr && (reg_addr == `OFF_INST);
    wire wr_sys = reg_wr && (reg_addr == `OFF_SYS);
    wire wr_idf = reg_wr && (reg_addr == `OFF_IDF);
    wire wr_addr = reg_wr && (reg_addr == `OFF_ADDR);
    wire wr_cmd = reg_wr && (reg_addr == `OFF_CMD) && reg_wdata[0];
    wire do_restore = (state == name_id_pkg::ST_RESTORE);

    // Packed NAME in protocol order so a plain compare decides arbitration.
    name_id_pkg::name_t next_name;
    assign next_name = '{arb_capable: 1'b0, ind_group: ind_group, vsys_inst: vsys_inst,
                         vsys: vsys, reserved: 1'b0, func: func, func_inst: func_inst,
                         ecu_inst: ecu_inst, maker: MAKER_CODE, ident: ident};

    name_id_pkg::can_id_t next_can_id;
    assign next_can_id = '{prio: prio, reserved: 1'b0, dpage: dpage, pdu_fmt: pdu_fmt,
                           pdu_spec: pdu_spec, addr: src_addr};

    // Broadcast formats carry group extension in PDU specific; peer formats zero it.
    wire next_bcast = (pdu_fmt >= `PDU_BCAST_MIN);
    wire [7:0] pgn_spec = next_bcast ? pdu_spec : 8'h00;
    wire [17:0] next_pgn = {1'b0, dpage, pdu_fmt, pgn_spec};
    wire next_indep = (func < `FUNC_INDEP_LIM);
    wire next_addr_valid = (src_addr <= `ADDR_LAST_USABLE);

    // Same address and rival strictly lower NAME: we give the address up.
    wire rival_wins = claim_seen && (rival_addr == src_addr)
                      && (rival_name < next_name);

    // *************************************************************
    // Restore sequencer.
    // *************************************************************
    // A restore spends one cycle in ST_RESTORE; a second command in that cycle is
    // absorbed, which is harmless because the defaults are being loaded then.
    always_comb
    begin
        next_state = state;
        case (state)
            name_id_pkg::ST_RUN:
            begin
                if (wr_cmd)
                begin
                    next_state = name_id_pkg::ST_RESTORE;
                end
            end
            default:
            begin
                next_state = name_id_pkg::ST_RUN;
            end
        endcase
    end

    // Sequencer state register.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            state <= name_id_pkg::ST_RUN;
        else
            state <= next_state;
    end

    // *************************************************************
    // Configuration registers; a restore overrides writes in the same cycle.
    // *************************************************************
    // Each write strobe touches only its own fields, so back-to-back writes never collide.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            func_inst <= `DEF_FUNC_INST;
            ecu_inst <= `DEF_ECU_INST;
            ind_group <= `DEF_IND_GROUP;
            vsys_inst <= `DEF_VSYS_INST;
            vsys <= `DEF_VSYS;
            func <= `DEF_FUNC;
            prio <= `DEF_PRIO;
            dpage <= `DEF_DPAGE;
            pdu_fmt <= `DEF_PDU_FMT;
            pdu_spec <= `DEF_PDU_SPEC;
            src_addr <= `DEF_ADDR;
        end
        else if (do_restore)
        begin
            // Kept apart from the reset branch so that the asynchronous load
            // stays a pure load of constants on the reset pin alone.
            func_inst <= `DEF_FUNC_INST;
            ecu_inst <= `DEF_ECU_INST;
            ind_group <= `DEF_IND_GROUP;
            vsys_inst <= `DEF_VSYS_INST;
            vsys <= `DEF_VSYS;
            func <= `DEF_FUNC;
            prio <= `DEF_PRIO;
            dpage <= `DEF_DPAGE;
            pdu_fmt <= `DEF_PDU_FMT;
            pdu_spec <= `DEF_PDU_SPEC;
            src_addr <= `DEF_ADDR;
        end
        else
        begin
            if (wr_inst)
            begin
                func_inst <= reg_wdata[7:3];
                ecu_inst <= reg_wdata[2:0];
            end
            if (wr_sys)
            begin
                ind_group <= reg_wdata[14:12];
                vsys_inst <= reg_wdata[11:8];
                vsys <= reg_wdata[6:0];
            end
            if (wr_idf)
            begin
                prio <= reg_wdata[26:24];
                dpage <= reg_wdata[16];
                pdu_fmt <= reg_wdata[15:8];
                pdu_spec <= reg_wdata[7:0];
            end
            if (wr_addr)
            begin
                src_addr <= reg_wdata[7:0];
                func <= reg_wdata[15:8];
            end
        end
    end

    // Identity number is a manufacture value: caught once after reset release.
    // Loading it from the parameter keeps the value out of reach of the register port.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ident <= `DEF_IDENT;
            ident_loaded <= 1'b0;
        end
        else if (!ident_loaded)
        begin
            ident <= IDENT_NUM;
            ident_loaded <= 1'b1;
        end
    end

    // *************************************************************
    // Registered outputs.
    // *************************************************************
    // Every output leaves a flip-flop, so the pins never see decode glitches;
    // the price is one cycle of lag behind the configuration registers.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            name_out <= '0;
            can_id <= '0;
            pgn <= 18'h00000;
            broadcast <= 1'b0;
            func_indep <= 1'b0;
            addr_valid <= 1'b0;
        end
        else
        begin
            name_out <= next_name;
            can_id <= next_can_id;
            pgn <= next_pgn;
            broadcast <= next_bcast;
            func_indep <= next_indep;
            addr_valid <= next_addr_valid;
        end
    end

    // Lost flag: set wins over the clear from a fresh address write.
    // The flag stays up until software writes the address register, even with the same address, or restores defaults.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            addr_lost <= 1'b0;
        else if (rival_wins)
            addr_lost <= 1'b1;
        else if (wr_addr || do_restore)
            addr_lost <= 1'b0;
    end

    // *************************************************************
    // Read path; unmapped offsets read zero.
    // *************************************************************
    // The word is selected here and registered below, so the master never waits.
    wire [31:0] rd_mux =
        (reg_addr == `OFF_INST) ? {24'h000000, func_inst, ecu_inst} :
        (reg_addr == `OFF_SYS) ? {17'h00000, ind_group, vsys_inst, 1'b0, vsys} :
        (reg_addr == `OFF_MAKER) ? {21'h000000, MAKER_CODE} :
        (reg_addr == `OFF_IDENT) ? {11'h000, ident} :
        (reg_addr == `OFF_IDF) ? {5'h00, prio, 7'h00, dpage, pdu_fmt, pdu_spec} :
        (reg_addr == `OFF_ADDR) ? {16'h0000, func, src_addr} :
        (reg_addr == `OFF_NAME_LO) ? name_out[31:0] :
        (reg_addr == `OFF_NAME_HI) ? name_out[63:32] :
        (reg_addr == `OFF_CANID) ? {3'h0, can_id} :
        (reg_addr == `OFF_PGN) ? {14'h0000, pgn} :
        (reg_addr == `OFF_CLAIM) ? {28'h0000000, addr_valid, func_indep, broadcast, addr_lost} :
        32'h00000000;

    // Read data stands only in the cycle after the strobe.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata <= 32'h00000000;
        else if (reg_rd)
            reg_rdata <= rd_mux;
        else
            reg_rdata <= 32'h00000000;
    end

    // *************************************************************
    // Checks.
    // *************************************************************
    // Restore path: registers hold defaults two edges after the command, outputs three.
    restore_prio_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wr_cmd |=> ##1 (prio == `DEF_PRIO && dpage == `DEF_DPAGE))
        else $error("restore did not reload priority and page");
    restore_inst_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wr_cmd |=> ##1 (func_inst == 5'h00 && ecu_inst == 3'h0 && vsys_inst == 4'h0))
        else $error("restore did not clear instances");
    restore_fmt_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wr_cmd |=> ##2 (can_id.pdu_fmt == `DEF_PDU_FMT && can_id.pdu_spec == `DEF_PDU_SPEC))
        else $error("restore did not reach identifier");

    // Write path: a field written in one cycle is held in the next; the ECU instance is checked in NAME one cycle after that.
    inst_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (wr_inst && !do_restore) |=> (func_inst == $past(reg_wdata[7:3])))
        else $error("function instance write lost");
    ecu_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (wr_inst && !do_restore) |=> ##1 (name_out.ecu_inst == $past(reg_wdata[2:0], 2)))
        else $error("ECU instance not in NAME");
    group_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (wr_sys && !do_restore) |=> (ind_group == $past(reg_wdata[14:12])))
        else $error("industry group write lost");
    vsys_inst_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (wr_sys && !do_restore) |=> (vsys_inst == $past(reg_wdata[11:8])))
        else $error("vehicle system instance write lost");
    vsys_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (wr_sys && !do_restore) |=> (vsys == $past(reg_wdata[6:0])))
        else $error("vehicle system write lost");
    page_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (wr_idf && !do_restore) |=>
        (dpage == $past(reg_wdata[16]) && prio == $past(reg_wdata[26:24])))
        else $error("page or priority write lost");
    fmt_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (wr_idf && !do_restore) |=>
        (pdu_fmt == $past(reg_wdata[15:8]) && pdu_spec == $past(reg_wdata[7:0])))
        else $error("format or specific write lost");
    func_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (wr_addr && !do_restore) |=> (func == $past(reg_wdata[15:8])))
        else $error("function write lost");
    addr_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (wr_addr && !do_restore) |=> (src_addr == $past(reg_wdata[7:0])))
        else $error("source address write lost");

    // Packing: outputs follow the registers one edge later; the edge that releases
    // reset is skipped because the outputs still hold their cleared values after it.
    id_pack_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        rst_n |=> (can_id[28:26] == $past(prio) && can_id[7:0] == $past(src_addr)))
        else $error("identifier packing wrong");
    name_pos_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        rst_n |=> (name_out[47:40] == $past(func) && name_out[39:35] == $past(func_inst)))
        else $error("NAME field order wrong");
    maker_fixed_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        rst_n |=> (name_out.maker == MAKER_CODE))
        else $error("maker code not fixed");
    ident_fixed_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ident_loaded |-> (ident == IDENT_NUM))
        else $error("identity number not fixed");
    bcast_flag_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        rst_n |=> (broadcast == ($past(pdu_fmt) >= `PDU_BCAST_MIN)))
        else $error("broadcast flag wrong");
    func_indep_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        rst_n |=> (func_indep == ($past(func) < `FUNC_INDEP_LIM)))
        else $error("function independence flag wrong");
    addr_valid_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        rst_n |=> (addr_valid == ($past(src_addr) <= `ADDR_LAST_USABLE)))
        else $error("address valid flag wrong");
    pgn_spec_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !broadcast |-> (pgn[7:0] == 8'h00))
        else $error("peer PGN kept PDU specific");
    pgn_bcast_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        broadcast |-> (pgn[7:0] == can_id.pdu_spec))
        else $error("broadcast PGN lost PDU specific");
    pgn_page_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (pgn[17] == 1'b0 && pgn[16] == can_id.dpage && pgn[15:8] == can_id.pdu_fmt))
        else $error("PGN page or format wrong");

    // Arbitration and read-back.
    claim_lost_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        rival_wins |=> addr_lost)
        else $error("lower rival NAME did not win");
    lost_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (addr_lost && !rival_wins && !wr_addr && !do_restore) |=> addr_lost)
        else $error("lost flag dropped on its own");
    canid_read_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (reg_rd && reg_addr == `OFF_CANID) |=> (reg_rdata == {3'h0, $past(can_id)}))
        else $error("identifier read wrong");
    read_idle_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !reg_rd |=> (reg_rdata == 32'h00000000))
        else $error("read data outside its cycle");

endmodule

// ---- src/name_id_defs.svh ----
// Offsets, reset values and field thresholds for the network identity block.
// Assumes inclusion by its bare name from the design file.
`ifndef NAME_ID_DEFS_SVH
`define NAME_ID_DEFS_SVH

// *************************************************************
// Register offsets (word index on the plain register port).
// *************************************************************
`define OFF_INST 4'h0
`define OFF_SYS 4'h1
`define OFF_MAKER 4'h2
`define OFF_IDENT 4'h3
`define OFF_IDF 4'h4
`define OFF_ADDR 4'h5
`define OFF_CMD 4'h6
`define OFF_NAME_LO 4'h7
`define OFF_NAME_HI 4'h8
`define OFF_CANID 4'h9
`define OFF_PGN 4'hA
`define OFF_CLAIM 4'hB

// *************************************************************
// Factory defaults.
// *************************************************************
`define DEF_FUNC_INST 5'h00
`define DEF_ECU_INST 3'h0
`define DEF_IND_GROUP 3'h0
`define DEF_VSYS_INST 4'h0
`define DEF_VSYS 7'h00
`define DEF_FUNC 8'hFF
`define DEF_IDENT 21'h000000
`define DEF_PRIO 3'h6
`define DEF_DPAGE 1'h1
`define DEF_PDU_FMT 8'hFF
`define DEF_PDU_SPEC 8'h00
`define DEF_ADDR 8'hFE

// *************************************************************
// Field thresholds.
// *************************************************************
`define PDU_BCAST_MIN 8'hF0
`define FUNC_INDEP_LIM 8'h80
`define ADDR_LAST_USABLE 8'hFC

`endif

// ---- src/name_id_pkg.sv ----
// Types shared by the network identity block.
// Assumes name_id_defs.svh is on the include path.
package name_id_pkg;

    // *************************************************************
    // Packed NAME fields, most significant first.
    // *************************************************************
    typedef struct packed {
        logic arb_capable;
        logic [2:0] ind_group;
        logic [3:0] vsys_inst;
        logic [6:0] vsys;
        logic reserved;
        logic [7:0] func;
        logic [4:0] func_inst;
        logic [2:0] ecu_inst;
        logic [10:0] maker;
        logic [20:0] ident;
    } name_t;

    // Packed 29-bit extended identifier.
    typedef struct packed {
        logic [2:0] prio;
        logic reserved;
        logic dpage;
        logic [7:0] pdu_fmt;
        logic [7:0] pdu_spec;
        logic [7:0] addr;
    } can_id_t;

    // Restore sequencing.
    typedef enum logic [0:0] {
        ST_RUN,
        ST_RESTORE
    } restore_state_t;

endpackage

// ---- tb/rival_node.sv ----
// Model of a rival node on the bus that presents address claims to the block.
// Assumes the bench pulses req for one cycle per claim, after a rising edge.
`timescale 1ns/1ps
module rival_node (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst_n,
    // Bench command.
    input wire logic req,
    input wire logic [63:0] req_name,
    input wire logic [7:0] req_addr,
    // Claim as seen by the block.
    output logic claim_seen,
    output logic [63:0] rival_name,
    output logic [7:0] rival_addr
);
    // One claim cycle per request.
    // Between claims the fields flip every cycle, so a stale value cannot pass for a claim.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            claim_seen <= 1'b0;
            rival_name <= 64'h0;
            rival_addr <= 8'h00;
        end
        else if (req)
        begin
            claim_seen <= 1'b1;
            rival_name <= req_name;
            rival_addr <= req_addr;
        end
        else
        begin
            claim_seen <= 1'b0;
            rival_name <= ~rival_name;
            rival_addr <= ~rival_addr;
        end
    end
endmodule

// ---- tb/test_name_id_config.sv ----
// Bench for the network identity block: registers, claims and restore.
// Assumes the design sources and rival_node.sv are compiled before it.
`timescale 1ns/1ps
module test_name_id_config;
    localparam logic [10:0] MK = 11'h155; // Arbitrary value.
    localparam logic [20:0] ID = 21'h00ABC; // Arbitrary value.
    // Design and partner signals.
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic req = 1'b0;
    logic [63:0] req_name = 64'h0;
    logic [7:0] req_addr = 8'h00;
    logic claim_seen;
    logic [63:0] rival_name;
    logic [7:0] rival_addr;
    name_id_pkg::name_t name_out;
    name_id_pkg::can_id_t can_id;
    logic [17:0] pgn;
    logic broadcast, func_indep, addr_valid, addr_lost;
    // Expected field values, kept beside every write.
    logic [4:0] fi;
    logic [2:0] ei, ig, pr;
    logic [3:0] vi;
    logic [6:0] vs;
    logic [7:0] fn, pf, ps, ad;
    logic dp, lost;
    logic [31:0] rv;
    integer seed = 32'hF0E7FBAE;
    int err_count = 0;
    int tests_run = 0;

    always #20 clk_sys = ~clk_sys;

    name_id_config #(.MAKER_CODE(MK), .IDENT_NUM(ID)) name_id_config_inst (
        .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .claim_seen(claim_seen),
        .rival_name(rival_name), .rival_addr(rival_addr), .name_out(name_out),
        .can_id(can_id), .pgn(pgn), .broadcast(broadcast), .func_indep(func_indep),
        .addr_valid(addr_valid), .addr_lost(addr_lost));
    rival_node rival_node_inst (.clk_sys(clk_sys), .rst_n(rst_n), .req(req),
        .req_name(req_name), .req_addr(req_addr), .claim_seen(claim_seen),
        .rival_name(rival_name), .rival_addr(rival_addr));

    // ************************************************
    // Expectations and bus helpers.
    // ************************************************
    function automatic logic [63:0] exp_name();
        return {1'b0, ig, vi, vs, 1'b0, fn, fi, ei, MK, ID};
    endfunction
    function automatic logic [28:0] exp_id();
        return {pr, 1'b0, dp, pf, ps, ad};
    endfunction
    // The specific byte only counts for broadcast formats.
    function automatic logic [17:0] exp_pgn();
        return {1'b0, dp, pf, (pf >= 8'hF0) ? ps : 8'h00};
    endfunction
    function automatic logic [3:0] exp_st();
        return {ad <= 8'hFC, fn < 8'h80, pf >= 8'hF0, lost};
    endfunction
    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        tests_run++;
        if (g !== e)
        begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the read strobe.
    task automatic rd(input logic [3:0] a, input logic [63:0] e);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk({32'h0, reg_rdata}, e);
    endtask
    task automatic setd();
        {fi, ei, ig, vi, vs, fn} = {5'h00, 3'h0, 3'h0, 4'h0, 7'h00, 8'hFF};
        {pr, dp, pf, ps, ad, lost} = {3'h6, 1'b1, 8'hFF, 8'h00, 8'hFE, 1'b0};
    endtask
    task automatic check_all();
        repeat (2) @(posedge clk_sys);
        #1;
        chk(name_out, exp_name());
        chk(can_id, exp_id());
        chk(pgn, exp_pgn());
        chk({addr_valid, func_indep, broadcast}, exp_st() >> 1);
        rd(4'h7, exp_name() & 64'h00000000FFFFFFFF);
        rd(4'h8, exp_name() >> 32);
        rd(4'h9, exp_id());
        rd(4'hA, exp_pgn());
        rd(4'hB, exp_st());
    endtask
    task automatic claim(input logic [63:0] n, input logic [7:0] a);
        @(posedge clk_sys);
        req <= 1'b1;
        req_name <= n;
        req_addr <= a;
        @(posedge clk_sys);
        req <= 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
        chk(addr_lost, lost);
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ************************************************
    // Main sequence and watchdog.
    // ************************************************
    initial
    begin
        setd();
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        check_all();
        // Read-only fields and a restore word with bit 0 clear must change nothing.
        wr(4'h2, 32'h2AA);
        wr(4'h3, 32'h1FFFFF);
        wr(4'h6, 32'hFFFFFFFE);
        rd(4'h2, MK);
        rd(4'h3, ID);
        rd(4'hF, 64'h0);
        check_all();
        $display("test defaults and read-only done");
        for (int i = 0; i < 12; i++)
        begin
            rv = $random(seed);
            {fi, ei, ig, vi, vs, fn} = rv[29:0];
            rv = $random(seed);
            {pr, dp, pf, ps, ad} = rv[27:0];
            // Boundary cases of the format, function and address thresholds first.
            if (i == 0)
                {pf, fn, ad} = {8'hF0, 8'h80, 8'hFC};
            if (i == 1)
                {pf, fn, ad} = {8'hEF, 8'h7F, 8'hFD};
            wr(4'h0, {rv[31:8], fi, ei});
            wr(4'h1, {17'h0, ig, vi, rv[31], vs});
            wr(4'h4, {5'h0, pr, 7'h0, dp, pf, ps});
            wr(4'h5, {16'h0, fn, ad});
            check_all();
        end
        $display("test random configuration done");
        claim(64'h0, ad + 8'h01);
        claim(64'hFFFFFFFFFFFFFFFF, ad);
        lost = 1'b1;
        claim(64'h0, ad);
        check_all();
        lost = 1'b0;
        wr(4'h5, {16'h0, fn, ad});
        check_all();
        lost = 1'b1;
        claim(64'h0, ad);
        $display("test address claim done");
        wr(4'h6, 32'h1);
        setd();
        repeat (2) @(posedge clk_sys);
        check_all();
        $display("test restore done");
        tally_and_finish();
    end

    initial
    begin
        #(40 * 4000);
        err_count++;
        $display("wrong value at %0t: run timed out", $time);
        tally_and_finish();
    end
endmodule
